// [fbrc_bank.sv]
`default_nettype none
// Contract
// RULE1: bank serves one side only, writer or reader, chosen by parameter.
// RULE2: every register is sixteen bits wide on both maps.
// RULE3: writer run request at offset 0 bit 0, applied at next control sample.
// RULE4: offset 1 bit 0 shows running; other bits read zero.
// RULE5: writer offset 2 counts finished frames kept for the reader.
// RULE6: writer offset 3 counts finished frames that were discarded.
// RULE7: offset 4 bit 0 set: drop and repeat follow programmed rates; only writer drops do, reader decisions follow spare_ready_in.
// RULE8: offset 4 bit 0 clear: decisions follow spare buffer availability only.
// RULE9: offset 5 holds input rate, write-only, reads return zero.
// RULE10: offset 6 holds output rate, write-only, reads return zero.
// RULE11: rate decisions depend only on ratio of input to output rate.
// RULE12: reader run request at offset 0; clearing halts at next update.
// RULE13: halted reader with dropping enabled lets input frames be discarded.
// RULE14: reader offset 2 counts finished frames that are not repeats.
// RULE15: reader offset 3 counts finished frames about to be repeated.
// RULE16: counters reset to zero and wrap silently at two to sixteen.
// RULE17: status one while processing, zero after halting on cleared request.
module fbrc_bank
	import fbrc_pkg::*;
#(
	parameter fbrc_side_type SIDE      = FBRC_WRITER,
	parameter int unsigned   EVT_DEPTH_P = fbrc_pkg::EVT_DEPTH
) (
	// clock and reset
	input  wire logic                         clk_in,
	input  wire logic                         rstn_in,
	// register port
	input  wire logic [fbrc_pkg::ADDR_W-1:0]  reg_address_in,
	input  wire logic                         reg_read_in,
	input  wire logic                         reg_write_in,
	input  wire logic [fbrc_pkg::DATA_W-1:0]  reg_writedata_in,
	output logic      [fbrc_pkg::DATA_W-1:0]  reg_readdata_out,
	output logic                              reg_readdatavalid_out,
	// control sampling from the datapath
	input  wire logic                         ctrl_sample_in,
	input  wire logic                         spare_ready_in,
	input  wire logic                         drop_enable_in,
	output logic                              run_out,
	output logic                              running_out,
	output logic                              decision_valid_out,
	output logic                              keep_frame_out,
	output logic                              discard_input_out,
	// finished frame events
	input  wire logic                         frame_done_valid_in,
	input  wire logic                         frame_done_alt_in,
	output logic                              frame_done_ready_out
);
	import fbrc_pkg::*;

	localparam logic [DATA_W:0] ACC_ZERO = 17'h0_0000;

	function automatic logic fbrc_hit(input logic [ADDR_W-1:0] addr,
	                                  input logic [ADDR_W-1:0] idx);
		fbrc_hit = (addr == idx);
	endfunction : fbrc_hit

	function automatic logic fbrc_mapped(input logic [ADDR_W-1:0] addr,
	                                     input fbrc_side_type side);
		if (side == FBRC_WRITER) begin
			fbrc_mapped = (addr <= IDX_OUT_RATE);
		end else begin
			fbrc_mapped = (addr <= IDX_ALT_CNT);
		end
	endfunction : fbrc_mapped

	// registers and their next values
	logic                run_req_q;
	logic                rate_en_q;
	logic [DATA_W-1:0]   in_rate_q;
	logic [DATA_W-1:0]   out_rate_q;
	logic [DATA_W:0]     acc_q;
	logic [DATA_W:0]     acc_d;
	fbrc_run_type        run_state_q;
	fbrc_run_type        run_state_d;
	logic [DATA_W-1:0]   readdata_q;
	logic                readvalid_q;
	logic                run_q;
	logic                running_q;
	logic                dec_valid_q;
	logic                keep_q;
	logic                discard_q;
	logic                evt_ready_q;

	// decoded strobes
	wire                 wr_ok;
	wire                 wr_control;
	wire                 wr_rate_en;
	wire                 wr_in_rate;
	wire                 wr_out_rate;
	wire                 rd_ok;
	wire                 is_writer;

	// counters and events
	wire [DATA_W-1:0]    pass_cnt;
	wire [DATA_W-1:0]    alt_cnt;
	wire                 evt_in_ready;
	wire                 evt_valid;
	wire [EVT_W-1:0]     evt_data;
	wire                 evt_pop;
	wire                 evt_ready_d;
	wire                 inc_pass;
	wire                 inc_alt;

	// decision path
	wire [DATA_W:0]      acc_sum;
	wire                 rate_keep;
	wire                 rate_usable;
	wire                 keep_d;
	wire                 running_d;
	wire [DATA_W-1:0]    rd_word;

	// RULE1 one side
	assign is_writer   = (SIDE == FBRC_WRITER);

	assign wr_ok       = reg_write_in & fbrc_mapped(reg_address_in, SIDE);
	assign rd_ok       = reg_read_in & fbrc_mapped(reg_address_in, SIDE);
	// RULE3 run request
	// RULE12 run request
	assign wr_control  = wr_ok & fbrc_hit(reg_address_in, IDX_CONTROL);
	assign wr_rate_en  = wr_ok & is_writer & fbrc_hit(reg_address_in, IDX_RATE_EN);
	// RULE9 input rate
	assign wr_in_rate  = wr_ok & is_writer & fbrc_hit(reg_address_in, IDX_IN_RATE);
	// RULE10 output rate
	assign wr_out_rate = wr_ok & is_writer & fbrc_hit(reg_address_in, IDX_OUT_RATE);

	// RULE2 sixteen bit words
	// RULE4 status bit only
	// RULE9 reads return zero
	// RULE10 reads return zero
	assign rd_word =
		fbrc_hit(reg_address_in, IDX_CONTROL)  ? {{(DATA_W-1){1'b0}}, run_req_q} :
		fbrc_hit(reg_address_in, IDX_STATE)    ? {{(DATA_W-1){1'b0}}, running_q} :
		fbrc_hit(reg_address_in, IDX_PASS_CNT) ? pass_cnt :
		fbrc_hit(reg_address_in, IDX_ALT_CNT)  ? alt_cnt :
		(fbrc_hit(reg_address_in, IDX_RATE_EN) && is_writer) ?
			{{(DATA_W-1){1'b0}}, rate_en_q} :
		RST_WORD;

	// control registers
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			run_req_q <= RST_RUN_REQ;
			rate_en_q <= RST_RATE_EN;
		end else begin
			if (wr_control) begin
				run_req_q <= reg_writedata_in[BIT_RUN_REQ];
			end
			if (wr_rate_en) begin
				rate_en_q <= reg_writedata_in[BIT_RATE_EN];
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			in_rate_q  <= RATE_DEFAULT;
			out_rate_q <= RATE_DEFAULT;
		end else begin
			if (wr_in_rate) begin
				in_rate_q <= reg_writedata_in;
			end
			if (wr_out_rate) begin
				out_rate_q <= reg_writedata_in;
			end
		end
	end

	// read answer, one cycle later
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			readdata_q  <= RST_WORD;
			readvalid_q <= 1'b0;
		end else begin
			readvalid_q <= reg_read_in;
			readdata_q  <= rd_ok ? rd_word : RST_WORD;
		end
	end

	// run state machine
	always_comb begin
		run_state_d = run_state_q;
		case (run_state_q)
			FBRC_HALTED: begin
				// RULE3 applied at sample
				if (ctrl_sample_in && run_req_q) begin
					run_state_d = FBRC_RUNNING;
				end
			end
			FBRC_RUNNING: begin
				if (!run_req_q) begin
					run_state_d = FBRC_STOPPING;
				end
			end
			FBRC_STOPPING: begin
				// RULE12 halt at next update
				if (ctrl_sample_in) begin
					run_state_d = run_req_q ? FBRC_RUNNING : FBRC_HALTED;
				end else if (run_req_q) begin
					run_state_d = FBRC_RUNNING;
				end
			end
			default: begin
				run_state_d = FBRC_HALTED;
			end
		endcase
	end

	// RULE17 status follows processing
	assign running_d = (run_state_d != FBRC_HALTED);

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			run_state_q <= FBRC_HALTED;
			running_q   <= 1'b0;
			run_q       <= 1'b0;
		end else begin
			run_state_q <= run_state_d;
			running_q   <= running_d;
			run_q       <= (run_state_d == FBRC_RUNNING);
		end
	end

	// RULE11 ratio accumulator
	assign acc_sum     = acc_q + {1'b0, out_rate_q};
	assign rate_usable = (in_rate_q != RST_WORD);
	assign rate_keep   = !rate_usable || (acc_sum >= {1'b0, in_rate_q});

	always_comb begin
		acc_d = acc_q;
		if (ctrl_sample_in && rate_en_q && rate_usable && is_writer) begin
			if (rate_keep) begin
				acc_d = acc_sum - {1'b0, in_rate_q};
			end else begin
				acc_d = acc_sum;
			end
		end
		if (wr_in_rate || wr_out_rate || wr_rate_en) begin
			acc_d = ACC_ZERO;
		end
	end

	// RULE7 rate governed
	// RULE8 spare buffer only
	assign keep_d = (rate_en_q && is_writer) ? rate_keep : spare_ready_in;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			acc_q       <= ACC_ZERO;
			dec_valid_q <= 1'b0;
			keep_q      <= 1'b0;
		end else begin
			acc_q       <= acc_d;
			dec_valid_q <= ctrl_sample_in;
			if (ctrl_sample_in) begin
				keep_q <= keep_d;
			end
		end
	end

	// RULE13 halted reader discards
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			discard_q <= 1'b0;
		end else begin
			discard_q <= !is_writer && !running_d && drop_enable_in;
		end
	end

	// frame end events
	fbrc_fifo #(
		.WIDTH (EVT_W),
		.DEPTH (EVT_DEPTH_P)
	) u_evt_fifo (
		.clk_in        (clk_in),
		.rstn_in       (rstn_in),
		.in_valid_in   (frame_done_valid_in & evt_ready_q),
		.in_data_in    (frame_done_alt_in),
		.in_ready_out  (evt_in_ready),
		.out_valid_out (evt_valid),
		.out_data_out  (evt_data),
		.out_ready_in  (!reg_read_in)
	);

	// keep counters still across a read
	assign evt_pop     = evt_valid & !reg_read_in;
	assign evt_ready_d = evt_in_ready;
	// RULE5 kept frames
	// RULE14 new frames
	assign inc_pass    = evt_pop & !evt_data[0];
	// RULE6 dropped frames
	// RULE15 repeated frames
	assign inc_alt     = evt_pop & evt_data[0];

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			evt_ready_q <= 1'b0;
		end else begin
			evt_ready_q <= evt_ready_d && !(frame_done_valid_in && evt_ready_q);
		end
	end

	// RULE16 wrapping counters
	fbrc_counter #(
		.WIDTH (DATA_W)
	) u_pass_cnt (
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.inc_in    (inc_pass),
		.value_out (pass_cnt)
	);

	fbrc_counter #(
		.WIDTH (DATA_W)
	) u_alt_cnt (
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.inc_in    (inc_alt),
		.value_out (alt_cnt)
	);

	assign reg_readdata_out      = readdata_q;
	assign reg_readdatavalid_out = readvalid_q;
	assign run_out               = run_q;
	assign running_out           = running_q;
	assign decision_valid_out    = dec_valid_q;
	assign keep_frame_out        = keep_q;
	assign discard_input_out     = discard_q;
	assign frame_done_ready_out  = evt_ready_q;
endmodule : fbrc_bank
`default_nettype wire

// [fbrc_bank_props.sv]
`default_nettype none
module fbrc_bank_props
	import fbrc_pkg::*;
(
	// clock and reset
	input wire logic                        clk_in,
	input wire logic                        rstn_in,
	// register port
	input wire logic [fbrc_pkg::ADDR_W-1:0] reg_address_in,
	input wire logic                        reg_read_in,
	input wire logic [fbrc_pkg::DATA_W-1:0] reg_readdata_out,
	input wire logic                        reg_readdatavalid_out,
	// control and events
	input wire logic                        ctrl_sample_in,
	input wire logic                        decision_valid_out,
	input wire logic                        run_out,
	input wire logic                        running_out,
	input wire logic                        frame_done_valid_in,
	input wire logic                        frame_done_ready_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	a_read_answer: assert property (reg_read_in |=> reg_readdatavalid_out)
		else $error("read not answered");
	a_answer_cause: assert property (reg_readdatavalid_out |-> $past(reg_read_in))
		else $error("answer without read");
	a_state_word: assert property (reg_readdatavalid_out && $past(reg_address_in) == IDX_STATE
		|-> reg_readdata_out == {15'h0000, $past(running_out)}) else $error("bad state word");
	a_rates_hidden: assert property (reg_readdatavalid_out
		&& ($past(reg_address_in) == IDX_IN_RATE || $past(reg_address_in) == IDX_OUT_RATE)
		|-> reg_readdata_out == 16'h0000) else $error("rate readable");
	a_decide_after: assert property (ctrl_sample_in |=> decision_valid_out)
		else $error("no decision");
	a_decide_cause: assert property (decision_valid_out |-> $past(ctrl_sample_in))
		else $error("decision without sample");
	a_start_sampled: assert property ($rose(run_out) && !$past(running_out)
		|-> $past(ctrl_sample_in)) else $error("started between samples");
	a_halt_sampled: assert property ($fell(running_out) |-> $past(ctrl_sample_in))
		else $error("halted between samples");
	a_run_status: assert property (run_out |-> running_out)
		else $error("running without status");
	a_event_gap: assert property (frame_done_valid_in && frame_done_ready_out
		|=> !frame_done_ready_out) else $error("ready held after event");
endmodule : fbrc_bank_props
bind fbrc_bank fbrc_bank_props chk_u (
	.clk_in(clk_in), .rstn_in(rstn_in), .reg_address_in(reg_address_in),
	.reg_read_in(reg_read_in), .reg_readdata_out(reg_readdata_out),
	.reg_readdatavalid_out(reg_readdatavalid_out), .ctrl_sample_in(ctrl_sample_in),
	.decision_valid_out(decision_valid_out), .run_out(run_out), .running_out(running_out),
	.frame_done_valid_in(frame_done_valid_in), .frame_done_ready_out(frame_done_ready_out)
);
`default_nettype wire

// [fbrc_counter.sv]
`default_nettype none
module fbrc_counter #(
	parameter int unsigned WIDTH = 16
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	// count
	input  wire logic             inc_in,
	output logic [WIDTH-1:0]      value_out
);
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			value_out <= '0;
		end else if (inc_in) begin
			// plain wrap, no flag
			value_out <= WIDTH'(value_out + 1'b1);
		end
	end
endmodule : fbrc_counter
`default_nettype wire

// [fbrc_evt_src.sv]
`default_nettype none
module fbrc_evt_src (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rstn_in,
	// command
	input  wire logic go_in,
	input  wire logic alt_in,
	output logic      busy_out,
	// event side
	output logic      valid_out,
	output logic      alt_out,
	input  wire logic ready_in
);
	timeunit 1ns;
	timeprecision 100ps;
	assign busy_out = valid_out;
	// holds event until taken, idle kind line toggles
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			valid_out <= 1'b0;
			alt_out <= 1'b0;
		end else if (valid_out && ready_in) begin
			valid_out <= 1'b0;
			alt_out <= ~alt_out;
		end else if (go_in && !valid_out) begin
			valid_out <= 1'b1;
			alt_out <= alt_in;
		end
	end
endmodule : fbrc_evt_src
`default_nettype wire

// [fbrc_fifo.sv]
`default_nettype none
module fbrc_fifo #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	// fill side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// drain side
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_ptr_q;
	logic [PW-1:0]    rd_ptr_q;
	logic [PW:0]      count_q;
	wire              push;
	wire              pop;
	wire  [PW:0]      count_d;

	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;
	assign count_d       = count_q + (PW+1)'(push) - (PW+1)'(pop);
	assign out_data_out  = mem_q[rd_ptr_q];
	assign out_valid_out = (count_q != '0);
	assign in_ready_out  = (count_q != (PW+1)'(DEPTH));

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			wr_ptr_q <= push ? PW'(wr_ptr_q + 1'b1) : wr_ptr_q;
			rd_ptr_q <= pop ? PW'(rd_ptr_q + 1'b1) : rd_ptr_q;
			count_q  <= count_d;
		end
	end
endmodule : fbrc_fifo
`default_nettype wire

// [fbrc_pkg.sv]
`default_nettype none
package fbrc_pkg;
	// register data width
	localparam int unsigned             DATA_W        = 16;
	localparam int unsigned             ADDR_W        = 3;
	// register indices
	localparam logic [ADDR_W-1:0]       IDX_CONTROL   = 3'h0;
	localparam logic [ADDR_W-1:0]       IDX_STATE     = 3'h1;
	localparam logic [ADDR_W-1:0]       IDX_PASS_CNT  = 3'h2;
	localparam logic [ADDR_W-1:0]       IDX_ALT_CNT   = 3'h3;
	localparam logic [ADDR_W-1:0]       IDX_RATE_EN   = 3'h4;
	localparam logic [ADDR_W-1:0]       IDX_IN_RATE   = 3'h5;
	localparam logic [ADDR_W-1:0]       IDX_OUT_RATE  = 3'h6;
	// field positions
	localparam int unsigned             BIT_RUN_REQ   = 0;
	localparam int unsigned             BIT_RUNNING   = 0;
	localparam int unsigned             BIT_RATE_EN   = 0;
	// reset values
	localparam logic                    RST_RUN_REQ   = 1'b0;
	localparam logic                    RST_RATE_EN   = 1'b0;
	localparam logic [DATA_W-1:0]       RST_WORD      = 16'h0000;
	localparam logic [DATA_W-1:0]       RATE_DEFAULT  = 16'h0001;
	// event fifo
	localparam int unsigned             EVT_DEPTH     = 16;
	localparam int unsigned             EVT_W         = 1;
	// which side the bank is attached to
	typedef enum logic [0:0] {
		FBRC_WRITER = 1'b0,
		FBRC_READER = 1'b1
	} fbrc_side_type;
	// run state, one-hot
	typedef enum logic [2:0] {
		FBRC_HALTED   = 3'b001,
		FBRC_RUNNING  = 3'b010,
		FBRC_STOPPING = 3'b100
	} fbrc_run_type;
endpackage : fbrc_pkg
`default_nettype wire

// [testbench.sv]
`default_nettype none
module testbench;
	import fbrc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic              clk_in = 1'b0;
	logic              rstn_in = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic              rd_s = 1'b0;
	logic              wr_s = 1'b0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] rdata;
	logic              smp_s = 1'b0;
	logic              spare = 1'b1;
	logic              drop_en = 1'b0;
	logic              keep;
	logic              go = 1'b0;
	logic              alt = 1'b0;
	logic              busy;
	logic              ev_v;
	logic              ev_a;
	logic              ev_r;
	logic [DATA_W-1:0] rdata_r;
	logic              keep_r;
	logic              disc_r;
	logic              disc_w;
	logic              rvalid;
	logic              run_w;
	logic              sts_w;
	logic              dec_w;
	int                failures = 0;
	int                checked = 0;
	logic [15:0]       rin[2] = '{16'h0002, 16'h0004};
	logic [15:0]       rout[2] = '{16'h0001, 16'h0002};
	always #2 clk_in = ~clk_in;
	fbrc_bank #(.SIDE(FBRC_WRITER)) dut_u (
		.clk_in(clk_in), .rstn_in(rstn_in), .reg_address_in(addr), .reg_read_in(rd_s),
		.reg_write_in(wr_s), .reg_writedata_in(wdata), .reg_readdata_out(rdata),
		.reg_readdatavalid_out(rvalid), .ctrl_sample_in(smp_s), .spare_ready_in(spare),
		.drop_enable_in(drop_en), .run_out(run_w), .running_out(sts_w),
		.decision_valid_out(dec_w),
		.keep_frame_out(keep), .discard_input_out(disc_w), .frame_done_valid_in(ev_v),
		.frame_done_alt_in(ev_a), .frame_done_ready_out(ev_r)
	);
	// reader side twin on the same bus and event stream
	fbrc_bank #(.SIDE(FBRC_READER)) dut_rd_u (
		.clk_in(clk_in), .rstn_in(rstn_in), .reg_address_in(addr), .reg_read_in(rd_s),
		.reg_write_in(wr_s), .reg_writedata_in(wdata), .reg_readdata_out(rdata_r),
		.reg_readdatavalid_out(), .ctrl_sample_in(smp_s), .spare_ready_in(spare),
		.drop_enable_in(drop_en), .run_out(), .running_out(), .decision_valid_out(),
		.keep_frame_out(keep_r), .discard_input_out(disc_r), .frame_done_valid_in(ev_v),
		.frame_done_alt_in(ev_a), .frame_done_ready_out()
	);
	fbrc_evt_src src_u (
		.clk_in(clk_in), .rstn_in(rstn_in), .go_in(go), .alt_in(alt), .busy_out(busy),
		.valid_out(ev_v), .alt_out(ev_a), .ready_in(ev_r)
	);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_in);
		wr_s <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_in);
		rd_s <= 1'b0;
		#1;
		chk(rdata, e);
		chk({15'h0000, rvalid}, 16'h0001);
	endtask : rd
	task automatic smp(input logic e);
		@(posedge clk_in);
		smp_s <= 1'b1;
		@(posedge clk_in);
		smp_s <= 1'b0;
		#1;
		chk({15'h0000, keep}, {15'h0000, e});
		chk({15'h0000, dec_w}, 16'h0001);
	endtask : smp
	task automatic ev(input logic a);
		@(posedge clk_in);
		go <= 1'b1;
		alt <= a;
		@(posedge clk_in);
		go <= 1'b0;
		for (int n = 0; n < 20; n++) begin
			#1;
			if (!busy) break;
			@(posedge clk_in);
		end
	endtask : ev
	task automatic print_verdict;
		$display("checks=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	initial begin
		#20000;
		failures++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'b1;
		rd(IDX_STATE, 16'h0000);
		rd(IDX_PASS_CNT, 16'h0000);
		rd(IDX_ALT_CNT, 16'h0000);
		rd(IDX_RATE_EN, 16'h0000);
		$display("test reset done");
		wr(IDX_CONTROL, 16'hffff);
		rd(IDX_CONTROL, 16'h0001);
		rd(IDX_STATE, 16'h0000);
		smp(1'b1);
		chk({15'h0000, run_w}, 16'h0001);
		chk({15'h0000, sts_w}, 16'h0001);
		rd(IDX_STATE, 16'h0001);
		chk(rdata_r, 16'h0001);
		wr(IDX_CONTROL, 16'h0000);
		rd(IDX_STATE, 16'h0001);
		chk(rdata_r, 16'h0001);
		smp(1'b1);
		rd(IDX_STATE, 16'h0000);
		chk(rdata_r, 16'h0000);
		@(posedge clk_in) drop_en <= 1'b1;
		@(posedge clk_in);
		#1;
		chk({15'h0000, disc_r}, 16'h0001);
		chk({15'h0000, disc_w}, 16'h0000);
		$display("test run control done");
		@(posedge clk_in) spare <= 1'b0;
		smp(1'b0);
		@(posedge clk_in) spare <= 1'b1;
		smp(1'b1);
		$display("test free regime done");
		wr(IDX_CONTROL, 16'h0001);
		foreach (rin[i]) begin
			wr(IDX_RATE_EN, 16'h0001);
			wr(IDX_IN_RATE, rin[i]);
			wr(IDX_OUT_RATE, rout[i]);
			@(posedge clk_in) spare <= 1'b0;
			for (int k = 0; k < 4; k++) smp(k[0]);
			@(posedge clk_in) spare <= 1'b1;
		end
		rd(IDX_IN_RATE, 16'h0000);
		rd(IDX_OUT_RATE, 16'h0000);
		rd(IDX_RATE_EN, 16'h0001);
		chk(rdata_r, 16'h0000);
		chk({15'h0000, keep_r}, 16'h0000);
		chk({15'h0000, disc_r}, 16'h0000);
		$display("test rate regime done");
		repeat (3) ev(1'b0);
		repeat (2) ev(1'b1);
		repeat (4) @(posedge clk_in);
		rd(IDX_PASS_CNT, 16'h0003);
		chk(rdata_r, 16'h0003);
		rd(IDX_ALT_CNT, 16'h0002);
		chk(rdata_r, 16'h0002);
		$display("test counters done");
		wr(3'h7, 16'hffff);
		rd(3'h7, 16'h0000);
		$display("test unmapped done");
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
